//--- hw/ssop_pkg.sv
// bit positions and reset values of the status octet packer
// assumes a single system clock; no register bus reaches these octets
package ssop_pkg;

  // ==========================================================
  // octet 4 field positions
  localparam int unsigned OCT4_VAR_LIMITED_SPEED_ON = 0;
  localparam int unsigned OCT4_STARTUP_PREVENTION_ON = 1;
  localparam int unsigned OCT4_SAFE_OUT_B9 = 2;
  localparam int unsigned OCT4_SAFE_OUT_B8 = 3;
  localparam int unsigned OCT4_SAFE_OUT_B7 = 4;
  localparam int unsigned OCT4_SAFE_OUT_A9 = 5;
  localparam int unsigned OCT4_SAFE_OUT_A8 = 6;
  localparam int unsigned OCT4_SAFE_OUT_A7 = 7;

  // ==========================================================
  // octet 5 field positions (bits 4 to 7 belong to other logic)
  localparam int unsigned OCT5_NET_ACK_REQUEST = 0;
  localparam int unsigned OCT5_LOCAL_ACK_REQUEST = 1;
  localparam int unsigned OCT5_TORQUE_OFF_CIRCUIT_OPEN = 2;
  localparam int unsigned OCT5_SPEED_POS_VALID = 3;

  // ==========================================================
  // octet 2 bit 0: feedback source encoding
  localparam logic FEEDBACK_ESTIMATE = 1'h0;
  localparam logic FEEDBACK_ENCODER = 1'h1;

  // ==========================================================
  // reset values
  localparam logic [7:0] OCTET_RESET = 8'h00;
  localparam logic BIT_RESET = 1'h0;

endpackage

//--- hw/ssop_ack_if.sv
// carries the local acknowledgement press, the network request and the gated result
// between the packer top and its acknowledgement gate
`timescale 1ns/100ps
`default_nettype none

interface ssop_ack_if;
  logic net_req;
  logic press;
  logic accept;

  modport top (output net_req, output press, input accept);
  modport gate (input net_req, input press, output accept);
endinterface

`default_nettype wire

//--- hw/ssop_ack_gate.sv
// gate for local acknowledgement from the safe inputs
// assumes press is synchronous to i_clk and already debounced
`timescale 1ns/100ps
`default_nettype none

module ssop_ack_gate
  import ssop_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  ssop_ack_if.gate ack
);

  // ==========================================================
  // edge detect and gate
  logic press_d_r;
  logic press_d_nxt;
  logic accept_r;
  logic accept_nxt;

  // one pulse per press made without network request; a held input acknowledges again only after a reset
  always_comb begin
    press_d_nxt = ack.press;
    accept_nxt = ack.press & ~press_d_r & ~ack.net_req;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      press_d_r <= BIT_RESET;
      accept_r <= BIT_RESET;
    end else begin
      press_d_r <= press_d_nxt;
      accept_r <= accept_nxt;
    end
  end

  assign ack.accept = accept_r;

endmodule

`default_nettype wire

//--- hw/ssop_packer.sv
// status octet packer: builds octets 4 and 5 and octet 2 bit 0
// of the cyclic safety status message; assumes all inputs are
// synchronous to i_clk and that the fieldbus layer samples the octets
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - octet4 bit0 = variable limit active and below
// - octet4 bit1 follows start-up prevention function
// - octet4 bits2-7 mirror six safe outputs
// - octet5 bit1 = local acknowledgement requested
// - local acknowledge accepted only without network request
// - octet5 bit2 set while torque-off circuit open
// - octet5 bit3 = speed and position valid
// - octet2 bit0 reports feedback source, 1=encoder
module ssop_packer
  import ssop_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_var_limited_speed_fn,
  input wire logic i_speed_below_var_limit,
  input wire logic i_startup_prevention_fn,
  input wire logic i_safe_out_a7,
  input wire logic i_safe_out_a8,
  input wire logic i_safe_out_a9,
  input wire logic i_safe_out_b7,
  input wire logic i_safe_out_b8,
  input wire logic i_safe_out_b9,
  input wire logic i_net_ack_request,
  input wire logic i_local_ack_request,
  input wire logic i_local_ack_press,
  input wire logic i_torque_off_circuit_open,
  input wire logic i_speed_pos_valid,
  input wire logic i_feedback_encoder,
  output logic [7:0] o_octet4,
  output logic [7:0] o_octet5,
  output logic o_feedback_type,
  output logic o_local_ack_accept
);

  // ==========================================================
  // octet state
  logic [7:0] octet4_r;
  logic [7:0] octet4_nxt;
  logic [7:0] octet5_r;
  logic [7:0] octet5_nxt;
  logic feedback_r;
  logic feedback_nxt;

  ssop_ack_if ack ();

  // ==========================================================
  // acknowledgement gate
  // the gate sees the raw network flag, not the registered copy,
  // so a press in the cycle the request rises is already refused
  assign ack.net_req = i_net_ack_request;
  assign ack.press = i_local_ack_press;

  ssop_ack_gate u_ack_gate (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .ack(ack.gate)
  );

  // ==========================================================
  // next octet values
  // all fields are plain levels; the host polls them cyclically,
  // so one cycle of latency costs nothing and keeps outputs glitch-free
  always_comb begin
    octet4_nxt = OCTET_RESET;
    octet5_nxt = OCTET_RESET;
    // monitoring is on only when active and below the limit
    octet4_nxt[OCT4_VAR_LIMITED_SPEED_ON] =
      i_var_limited_speed_fn & i_speed_below_var_limit;
    octet4_nxt[OCT4_STARTUP_PREVENTION_ON] = i_startup_prevention_fn;
    octet4_nxt[OCT4_SAFE_OUT_B9] = i_safe_out_b9;
    octet4_nxt[OCT4_SAFE_OUT_B8] = i_safe_out_b8;
    octet4_nxt[OCT4_SAFE_OUT_B7] = i_safe_out_b7;
    octet4_nxt[OCT4_SAFE_OUT_A9] = i_safe_out_a9;
    octet4_nxt[OCT4_SAFE_OUT_A8] = i_safe_out_a8;
    octet4_nxt[OCT4_SAFE_OUT_A7] = i_safe_out_a7;
    octet5_nxt[OCT5_NET_ACK_REQUEST] = i_net_ack_request;
    octet5_nxt[OCT5_LOCAL_ACK_REQUEST] = i_local_ack_request;
    // open circuit says nothing about the motor having stopped
    octet5_nxt[OCT5_TORQUE_OFF_CIRCUIT_OPEN] = i_torque_off_circuit_open;
    // validity is passed as given; the host combines it with octet 2
    octet5_nxt[OCT5_SPEED_POS_VALID] = i_speed_pos_valid;
    feedback_nxt = i_feedback_encoder ? FEEDBACK_ENCODER : FEEDBACK_ESTIMATE;
  end

  // register the octets
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      octet4_r <= OCTET_RESET;
      octet5_r <= OCTET_RESET;
      feedback_r <= FEEDBACK_ESTIMATE;
    end else begin
      octet4_r <= octet4_nxt;
      octet5_r <= octet5_nxt;
      feedback_r <= feedback_nxt;
    end
  end

  // ==========================================================
  // outputs, each straight from a flip-flop
  assign o_octet4 = octet4_r;
  assign o_octet5 = octet5_r;
  assign o_feedback_type = feedback_r;
  assign o_local_ack_accept = ack.accept;

  // ==========================================================
  // checks
  // every antecedent outside chk_local_ack_gate, chk_accept_one_cycle and chk_accept_cause also wants i_rst low at its own edge: a reset released
  // by that edge has still cleared the flops there, while disable iff
  // already sees it low and would let a stale comparison through

  // monitoring flag needs both the function and the speed condition
  chk_var_speed_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && !$past(i_rst) |-> o_octet4[OCT4_VAR_LIMITED_SPEED_ON] ==
      ($past(i_var_limited_speed_fn) && $past(i_speed_below_var_limit)))
    else $error("variable limited speed flag wrong");

  // monitoring flag is off whenever speed is at or above the limit
  chk_var_speed_off: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && !i_speed_below_var_limit |=> !o_octet4[OCT4_VAR_LIMITED_SPEED_ON])
    else $error("variable limited speed flag set above the limit");

  // start-up prevention flag tracks the function one cycle later
  chk_startup_prev_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && $rose(i_startup_prevention_fn) |=> o_octet4[OCT4_STARTUP_PREVENTION_ON])
    else $error("start-up prevention flag did not follow");

  // start-up prevention flag clears one cycle after the function ends
  chk_startup_prev_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && $fell(i_startup_prevention_fn) |=> !o_octet4[OCT4_STARTUP_PREVENTION_ON])
    else $error("start-up prevention flag did not clear");

  // start-up prevention flag is a plain copy of the function level
  chk_startup_prev_level: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && !$past(i_rst) |-> o_octet4[OCT4_STARTUP_PREVENTION_ON] ==
      $past(i_startup_prevention_fn))
    else $error("start-up prevention flag level wrong");

  // safe outputs in the documented bit order
  chk_safe_out_order: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && !$past(i_rst) |-> o_octet4[7:2] ==
      {$past(i_safe_out_a7), $past(i_safe_out_a8),
      $past(i_safe_out_a9), $past(i_safe_out_b7), $past(i_safe_out_b8),
      $past(i_safe_out_b9)})
    else $error("safe output bits out of order");

  // local request flag follows its source
  chk_local_req_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && !$past(i_rst) |->
      o_octet5[OCT5_LOCAL_ACK_REQUEST] == $past(i_local_ack_request))
    else $error("local acknowledgement request flag wrong");

  // never accept a press while the network asks for acknowledgement
  chk_local_ack_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    i_net_ack_request |=> !o_local_ack_accept)
    else $error("local acknowledgement accepted during network request");

  // a fresh press without network request is accepted next cycle
  chk_local_ack_taken: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_rst && !i_net_ack_request && i_local_ack_press && !$past(i_local_ack_press)
      && !$past(i_rst)) |=> o_local_ack_accept ##1 !o_local_ack_accept)
    else $error("local acknowledgement press not accepted once");

  // accept is a single-cycle pulse, a held press never stretches it
  chk_accept_one_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
    o_local_ack_accept |=> !o_local_ack_accept)
    else $error("local acknowledgement accept held too long");

  // every accept traces back to a press taken without network request
  chk_accept_cause: assert property (@(posedge i_clk) disable iff (i_rst)
    o_local_ack_accept |-> $past(i_local_ack_press) && !$past(i_net_ack_request))
    else $error("local acknowledgement accepted without cause");

  // torque-off circuit flag holds while the circuit stays open
  chk_torque_off_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_rst && i_torque_off_circuit_open) [*2] |->
      o_octet5[OCT5_TORQUE_OFF_CIRCUIT_OPEN])
    else $error("torque-off circuit flag dropped while open");

  // torque-off flag clears once the circuit has closed
  chk_torque_off_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && !i_torque_off_circuit_open |=> !o_octet5[OCT5_TORQUE_OFF_CIRCUIT_OPEN])
    else $error("torque-off circuit flag stuck after close");

  // torque-off flag copies the circuit state level
  chk_torque_off_level: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && !$past(i_rst) |->
      o_octet5[OCT5_TORQUE_OFF_CIRCUIT_OPEN] == $past(i_torque_off_circuit_open))
    else $error("torque-off circuit flag level wrong");

  // validity flag falls one cycle after its source falls
  chk_valid_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && $fell(i_speed_pos_valid) |=> !o_octet5[OCT5_SPEED_POS_VALID])
    else $error("speed and position validity flag stuck");

  // validity flag rises one cycle after its source rises
  chk_valid_set: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && $rose(i_speed_pos_valid) |=> o_octet5[OCT5_SPEED_POS_VALID])
    else $error("speed and position validity flag did not rise");

  // validity flag copies its source level
  chk_valid_level: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && !$past(i_rst) |->
      o_octet5[OCT5_SPEED_POS_VALID] == $past(i_speed_pos_valid))
    else $error("speed and position validity flag level wrong");

  // network request flag and upper nibble of octet 5
  chk_net_req_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && !$past(i_rst) |->
      o_octet5[OCT5_NET_ACK_REQUEST] == $past(i_net_ack_request)
      && o_octet5[7:4] == 4'h0)
    else $error("network acknowledgement request flag wrong");

  // feedback source encoding, encoder reads as one
  chk_feedback_type: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && $changed(i_feedback_encoder) |=>
      o_feedback_type == $past(i_feedback_encoder))
    else $error("feedback source bit wrong");

  // feedback source bit copies the encoder select level
  chk_feedback_level: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && !$past(i_rst) |-> o_feedback_type == $past(i_feedback_encoder))
    else $error("feedback source bit level wrong");

endmodule

`default_nettype wire

//--- testbench/ssop_host_model.sv
// host side model: reads the status octets of the packer
// assumes octets come straight from the packer top, no fieldbus delay
`timescale 1ns/100ps
`default_nettype none

module ssop_host_model (
  input wire logic [7:0] i_octet5,
  input wire logic i_feedback_type,
  output logic o_pos_trusted
);
  // ========================================
  // position trusted only with encoder feedback, whatever the flag says;
  // the ack request bits are hints only, so nothing here leans on them
  assign o_pos_trusted = i_octet5[3] & i_feedback_type;
endmodule

`default_nettype wire

//--- testbench/tb_safety_status_octet_packer.sv
// self-checking bench for the status octet packer
// assumes one 25 MHz clock and the host model beside the packer
`timescale 1ns/100ps
`default_nettype none

module tb_safety_status_octet_packer;
  import ssop_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [13:0] drv = 14'h0000;
  logic press = 1'h0;
  logic [7:0] oct4, oct5;
  logic fb, accept, trusted;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  // rows: {inputs fn,below,startup_prevention_fn,a7,a8,a9,b7,b8,b9,net,loc,sto,valid,enc, octet4, octet5, fb}
  localparam logic [30:0] ROWS [16] = '{
    {14'h2000, 8'h00, 8'h00, 1'h0}, {14'h3000, 8'h01, 8'h00, 1'h0},
    {14'h1000, 8'h00, 8'h00, 1'h0}, {14'h0800, 8'h02, 8'h00, 1'h0},
    {14'h0400, 8'h80, 8'h00, 1'h0}, {14'h0200, 8'h40, 8'h00, 1'h0},
    {14'h0100, 8'h20, 8'h00, 1'h0}, {14'h0080, 8'h10, 8'h00, 1'h0},
    {14'h0040, 8'h08, 8'h00, 1'h0}, {14'h0020, 8'h04, 8'h00, 1'h0},
    {14'h0010, 8'h00, 8'h01, 1'h0}, {14'h0008, 8'h00, 8'h02, 1'h0},
    {14'h0004, 8'h00, 8'h04, 1'h0}, {14'h0002, 8'h00, 8'h08, 1'h0},
    {14'h0001, 8'h00, 8'h00, 1'h1}, {14'h3FFF, 8'hFF, 8'h0F, 1'h1}};

  // 40 ns clock
  always #20 clk = ~clk;

  ssop_packer u_dut (
    .i_clk(clk), .i_rst(rst),
    .i_var_limited_speed_fn(drv[13]), .i_speed_below_var_limit(drv[12]),
    .i_startup_prevention_fn(drv[11]),
    .i_safe_out_a7(drv[10]), .i_safe_out_a8(drv[9]), .i_safe_out_a9(drv[8]),
    .i_safe_out_b7(drv[7]), .i_safe_out_b8(drv[6]), .i_safe_out_b9(drv[5]),
    .i_net_ack_request(drv[4]), .i_local_ack_request(drv[3]),
    .i_local_ack_press(press), .i_torque_off_circuit_open(drv[2]),
    .i_speed_pos_valid(drv[1]), .i_feedback_encoder(drv[0]),
    .o_octet4(oct4), .o_octet5(oct5), .o_feedback_type(fb),
    .o_local_ack_accept(accept));

  ssop_host_model u_host (.i_octet5(oct5), .i_feedback_type(fb), .o_pos_trusted(trusted));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // press from low with the network flag set as given, then hold it high
  task automatic ack_try(input logic net, input logic exp);
    @(posedge clk);
    drv <= {9'h000, net, 4'h0};
    press <= 1'h0;
    @(posedge clk);
    press <= 1'h1;
    @(posedge clk);
    #1 check({7'h00, accept}, {7'h00, exp});
    @(posedge clk);
    #1 check({7'h00, accept}, 8'h00);
  endtask

  // hang guard: the whole run needs well under 200 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    #1 check(oct4 | oct5 | {6'h00, fb, accept}, 8'h00);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      drv <= ROWS[i][30:17];
      @(posedge clk);
      #1 check(oct4, ROWS[i][16:9]);
      check(oct5, ROWS[i][8:1]);
      check({7'h00, fb}, {7'h00, ROWS[i][0]});
      check({7'h00, trusted}, {7'h00, ROWS[i][4] & ROWS[i][0]});
    end
    $display("test rows done");
    ack_try(1'h0, 1'h1);
    ack_try(1'h1, 1'h0);
    ack_try(1'h0, 1'h1);
    $display("test local ack done");
    // mid-run reset clears everything at once; press stays held high
    @(posedge clk);
    drv <= 14'h3FEF;
    rst <= 1'h1;
    #1 check(oct4 | oct5 | {6'h00, fb, accept}, 8'h00);
    @(posedge clk);
    rst <= 1'h0;
    // first edge after release registers inputs; the held press counts as fresh
    @(posedge clk);
    #1 check(oct4, 8'hFF);
    check(oct5, 8'h0E);
    check({7'h00, fb}, 8'h01);
    check({7'h00, trusted}, 8'h01);
    check({7'h00, accept}, 8'h01);
    @(posedge clk);
    #1 check({7'h00, accept}, 8'h00);
    $display("test reset done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
